//--- rtl/wake_limit_pkg.sv
// Constants, types and timing figures for the wake-up and current-limit control.
// Assumes one 25 MHz system clock; analog comparators arrive as digital levels.
// Functional notes
// [RQ1] Mode pin low straps, high uses registers
// [RQ2] Controller inverts line about 80 us
// [RQ3] Driver off: valid receive toggle pulses wake
// [RQ4] Driver on: valid limit current pulses wake
// [RQ5] Too short or long current: no wake
// [RQ6] Register mode also sets wake flag
// [RQ7] Register mode disable bit suppresses wake
// [RQ8] Strap mode wake always enabled
// [RQ9] Auxiliary channel never raises wake
// [RQ10] Controller enters receive within 500 us
// [RQ11] Separate limit settings per channel
// [RQ12] Floating strap: report only, no blanking
// [RQ13] Grounded strap: controller mode, no fault
// [RQ14] Controller mode sinks when driver off
// [RQ15] Register limit from bits 7 to 5
// [RQ16] Auto retry: on for blank each interval
// [RQ17] Strap mode fault drives fault low
// [RQ18] Timing measured by parameterised counters
package wake_limit_pkg;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_MHZ = 25;
  localparam int WAKE_MIN_US = 60;
  localparam int WAKE_MAX_US = 110;
  localparam int WAKE_PULSE_US = 100;
  localparam int BLANK_US = 200;
  localparam int RETRY_US = 10000;
  localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_US * CLK_MHZ;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  // ***************************************************
  // Fields and encodings
  // ***************************************************
  localparam int LIM_MSB = 7;
  localparam int LIM_LSB = 5;
  localparam logic [7:0] LIMIT_REG_RST = 8'h00;
  // Strap condition as sensed by the analog front end
  typedef enum logic [1:0] {
    STRAP_RES = 2'b00,
    STRAP_GND = 2'b01,
    STRAP_OPEN = 2'b10
  } strap_t;
  // Per-channel fault policy
  typedef struct packed {
    logic report;
    logic blank;
    logic retry;
    logic ctrl_mode;
  } policy_t;
  // Per-channel analog status
  typedef struct packed {
    logic drv_en;
    logic over_cur;
  } chan_in_t;
endpackage

//--- rtl/wakeup_and_current_limit_ctrl.sv
// Wake-up detection and over-current policy for a line and an auxiliary channel.
// Assumes comparator, receive and driver-enable levels are asynchronous and synchronised here; transmit and configuration inputs are used unsynchronised.
`timescale 1ns/1ns
module wakeup_and_current_limit_ctrl
  import wake_limit_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int BLANK_CYCLES = BLANK_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Mode and configuration
  input wire logic MODE_SERIAL,
  input wire logic WAKE_SIGNAL_DISABLE,
  input wire logic [7:0] LINE_LIMIT_REG,
  input wire logic [7:0] AUX_OUT_LIMIT_REG,
  input wire logic LINE_AUTO_RETRY,
  input wire logic AUX_AUTO_RETRY,
  input wire strap_t LINE_LIMIT_STRAP,
  input wire strap_t AUX_LIMIT_STRAP,
  input wire logic [2:0] STRAP_LIMIT_CODE_LINE,
  input wire logic [2:0] STRAP_LIMIT_CODE_AUX,
  // Line channel
  input wire logic LINE_DRIVER_ENABLE,
  input wire logic LINE_TRANSMIT_IN,
  input wire logic LINE_RECEIVE_OUT,
  input wire logic LINE_OVER_CUR,
  // Auxiliary channel
  input wire logic AUX_DRIVER_ENABLE,
  input wire logic AUX_OVER_CUR,
  // Wake outputs
  output logic WAKE_NOTIFY_PIN_O,
  output logic WAKE_NOTIFY_PIN_OE,
  output logic WAKE_IRQ_FLAG,
  input wire logic WAKE_IRQ_CLEAR,
  output logic WAKE_HIGH_LEVEL,
  // Driver control and faults
  output logic [2:0] LINE_OUTPUT_CURRENT_LIMIT,
  output logic [2:0] AUX_OUTPUT_CURRENT_LIMIT,
  output logic LINE_OUT_ALLOW,
  output logic AUX_OUT_ALLOW,
  output logic LINE_SINK_ON,
  output logic AUX_SINK_ON,
  output logic LINE_FAULT_N_O,
  output logic LINE_FAULT_N_OE,
  output logic AUX_FAULT_N_O,
  output logic AUX_FAULT_N_OE
);
  // ***************************************************
  // Input synchronisers: three stages, second and third must agree
  // ***************************************************
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
  assign raw_in = {AUX_OVER_CUR, LINE_OVER_CUR, LINE_RECEIVE_OUT,
                   LINE_DRIVER_ENABLE, AUX_DRIVER_ENABLE};
  // Sync chain
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Accept a level once two late stages agree; filters one-cycle glitches
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      clean_reg <= '0;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          clean_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  chan_in_t line_in, aux_in;
  logic rx_lvl;
  assign line_in = '{drv_en: clean_reg[1], over_cur: clean_reg[3]};
  assign aux_in = '{drv_en: clean_reg[0], over_cur: clean_reg[4]};
  assign rx_lvl = clean_reg[2];

  // ***************************************************
  // Wake window measurement
  // ***************************************************
  logic rx_last_reg;
  logic [15:0] win_reg; // Cycles the candidate condition has held
  logic cand; // Condition that may be a wake pulse
  logic cand_last_reg;
  logic wake_evt; // One-cycle valid wake
  logic wake_en;
  logic [2:0] settle_reg; // Cycles since reset, saturating at SETTLE_CYC
  logic primed; // Chain flushed, so the receive baseline is valid
  localparam int SETTLE_CYC = 6;
  // Baseline follows the chain until it flushes: its reset value is no toggle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      settle_reg <= '0;
    end else if (!primed) begin
      settle_reg <= settle_reg + 3'd1;
    end
  end
  assign primed = (settle_reg == 3'(SETTLE_CYC));
  // Driver off: receive level changed; driver on: limit current present
  assign cand = primed && (line_in.drv_en ? line_in.over_cur // RQ4
                                          : (rx_lvl != rx_last_reg)); // RQ3
  // Strap mode ignores the disable bit entirely
  assign wake_en = !(MODE_SERIAL && WAKE_SIGNAL_DISABLE); // RQ7 RQ8 RQ1
  // Remember receive level at start of a toggle; it holds while toggled
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_last_reg <= 1'b0;
    end else if (line_in.drv_en || !cand) begin
      rx_last_reg <= rx_lvl;
    end else if (win_reg >= 16'(WAKE_MAX_CYC)) begin
      rx_last_reg <= rx_lvl; // Too long: new level becomes the baseline
    end
  end
  // Window counter saturates just past the maximum
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      win_reg <= '0;
      cand_last_reg <= 1'b0;
    end else begin
      cand_last_reg <= cand;
      if (!cand) begin
        win_reg <= '0;
      end else if (win_reg <= 16'(WAKE_MAX_CYC)) begin
        win_reg <= win_reg + 16'd1; // RQ18
      end
    end
  end
  // A wake is the end of a candidate whose length fell inside the window
  assign wake_evt = cand_last_reg && !cand && wake_en
                    && win_reg > 16'(WAKE_MIN_CYC) && win_reg < 16'(WAKE_MAX_CYC); // RQ5 RQ9

  // ***************************************************
  // Wake pulse and flag
  // ***************************************************
  logic [15:0] pulse_reg;
  // Open-drain low pulse for the indication time
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pulse_reg <= '0;
    end else if (wake_evt) begin
      pulse_reg <= 16'(WAKE_PULSE_CYC); // RQ3 RQ4
    end else if (pulse_reg != 16'd0) begin
      pulse_reg <= pulse_reg - 16'd1;
    end
  end
  assign WAKE_NOTIFY_PIN_O = 1'b0;
  assign WAKE_NOTIFY_PIN_OE = (pulse_reg != 16'd0);
  // Sticky flag in register mode; a new wake beats a clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WAKE_IRQ_FLAG <= 1'b0;
    end else if (wake_evt && MODE_SERIAL) begin
      WAKE_IRQ_FLAG <= 1'b1; // RQ6
    end else if (WAKE_IRQ_CLEAR) begin
      WAKE_IRQ_FLAG <= 1'b0;
    end
  end
  // Driver on: transmit high means a high-level request; driver off: the receive level from before the toggle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WAKE_HIGH_LEVEL <= 1'b0;
    end else if (wake_evt) begin
      WAKE_HIGH_LEVEL <= line_in.drv_en ? LINE_TRANSMIT_IN : rx_last_reg; // RQ4
    end
  end

  // ***************************************************
  // Current limit selection, one setting per channel
  // ***************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      LINE_OUTPUT_CURRENT_LIMIT <= LIMIT_REG_RST[LIM_MSB:LIM_LSB];
      AUX_OUTPUT_CURRENT_LIMIT <= LIMIT_REG_RST[LIM_MSB:LIM_LSB];
    end else begin
      LINE_OUTPUT_CURRENT_LIMIT <= MODE_SERIAL ? LINE_LIMIT_REG[LIM_MSB:LIM_LSB]
                                               : STRAP_LIMIT_CODE_LINE; // RQ11 RQ15
      AUX_OUTPUT_CURRENT_LIMIT <= MODE_SERIAL ? AUX_OUT_LIMIT_REG[LIM_MSB:LIM_LSB]
                                              : STRAP_LIMIT_CODE_AUX; // RQ11 RQ15
    end
  end

  // ***************************************************
  // Fault policy per channel
  // ***************************************************
  function automatic policy_t pick(logic serial, strap_t s, logic retry_en);
    policy_t p;
    p = '{report: 1'b1, blank: 1'b1, retry: 1'b1, ctrl_mode: 1'b0};
    if (serial) begin
      p.retry = retry_en;
    end else if (s == STRAP_OPEN) begin
      p = '{report: 1'b1, blank: 1'b0, retry: 1'b0, ctrl_mode: 1'b0}; // RQ12
    end else if (s == STRAP_GND) begin
      p = '{report: 1'b0, blank: 1'b0, retry: 1'b0, ctrl_mode: 1'b1}; // RQ13
    end
    return p;
  endfunction
  policy_t pol [2];
  assign pol[0] = pick(MODE_SERIAL, LINE_LIMIT_STRAP, LINE_AUTO_RETRY);
  assign pol[1] = pick(MODE_SERIAL, AUX_LIMIT_STRAP, AUX_AUTO_RETRY);
  chan_in_t cin [2];
  assign cin[0] = line_in;
  assign cin[1] = aux_in;
  logic [1:0] allow, sink, fault;
  logic [1:0] fault_reg; // Registered fault state per channel
  logic [1:0] off_reg; // Output turned off by auto retry
  logic [23:0] blk_reg [2];
  logic [23:0] ret_reg [2];
  for (genvar c = 0; c < 2; c++) begin : g_ch
    // Blanking, fault detection and retry timing
    always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
        blk_reg[c] <= '0;
        ret_reg[c] <= '0;
        fault_reg[c] <= 1'b0;
        off_reg[c] <= 1'b0;
      end else if (!cin[c].drv_en || pol[c].ctrl_mode) begin
        // Indicator inactive while the driver is off or the channel is in controller mode
        blk_reg[c] <= '0;
        ret_reg[c] <= '0;
        fault_reg[c] <= 1'b0;
        off_reg[c] <= 1'b0;
      end else if (off_reg[c]) begin
        if (ret_reg[c] < 24'(RETRY_CYCLES)) begin
          ret_reg[c] <= ret_reg[c] + 24'd1;
        end else begin
          ret_reg[c] <= '0; // Retry: on again for one blank interval
          off_reg[c] <= 1'b0;
          blk_reg[c] <= '0; // RQ16
        end
      end else if (cin[c].over_cur) begin
        if (!pol[c].blank || blk_reg[c] >= 24'(BLANK_CYCLES)) begin
          fault_reg[c] <= pol[c].report; // RQ12
          off_reg[c] <= pol[c].retry; // RQ16
        end else begin
          blk_reg[c] <= blk_reg[c] + 24'd1; // RQ18
        end
      end else begin
        blk_reg[c] <= '0;
        fault_reg[c] <= 1'b0; // Over-current gone
      end
    end
    assign allow[c] = !off_reg[c];
    assign sink[c] = pol[c].ctrl_mode && !cin[c].drv_en; // RQ14
    assign fault[c] = fault_reg[c] && !MODE_SERIAL; // RQ17
  end
  assign LINE_OUT_ALLOW = allow[0];
  assign AUX_OUT_ALLOW = allow[1];
  assign LINE_SINK_ON = sink[0];
  assign AUX_SINK_ON = sink[1];
  assign LINE_FAULT_N_O = 1'b0;
  assign LINE_FAULT_N_OE = fault[0];
  assign AUX_FAULT_N_O = 1'b0;
  assign AUX_FAULT_N_OE = fault[1];

  // ***************************************************
  // Assertions
  // ***************************************************
  sequence s_wake_fire;
    wake_evt;
  endsequence
  a_wake_pulse_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ3
    s_wake_fire |=> WAKE_NOTIFY_PIN_OE [*8])
    else $error("wake pulse not held low");
  a_wake_disabled: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ7
    (MODE_SERIAL && WAKE_SIGNAL_DISABLE) |-> !wake_evt)
    else $error("wake raised while disabled");
  a_flag_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ6
    (MODE_SERIAL && wake_evt) |=> WAKE_IRQ_FLAG)
    else $error("wake flag not set");
  a_gnd_no_fault: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ13
    (!MODE_SERIAL && LINE_LIMIT_STRAP == STRAP_GND) |=> !LINE_FAULT_N_OE || $past(MODE_SERIAL))
    else $error("fault shown in controller mode");
  a_sink_on: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ14
    (!MODE_SERIAL && LINE_LIMIT_STRAP == STRAP_GND && !line_in.drv_en) |-> LINE_SINK_ON)
    else $error("sink off in controller mode");
  a_open_no_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ12
    (!MODE_SERIAL && $stable(LINE_LIMIT_STRAP) && LINE_LIMIT_STRAP == STRAP_OPEN
     && $past(LINE_OUT_ALLOW)) |-> LINE_OUT_ALLOW)
    else $error("output disabled with open strap");
  a_limit_field: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ15
    MODE_SERIAL |=> LINE_OUTPUT_CURRENT_LIMIT == $past(LINE_LIMIT_REG[LIM_MSB:LIM_LSB]))
    else $error("limit not from register field");
  a_serial_no_pin: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ17
    MODE_SERIAL |-> !LINE_FAULT_N_OE && !AUX_FAULT_N_OE)
    else $error("fault pin driven in register mode");
endmodule

//--- tb/bus_ctrl_node.sv
// Behavioural far-side bus controller: drives wake-up and over-current episodes.
// Assumes the bench pulses go for one cycle with the kind and length of an episode.
`timescale 1ns/1ns
module bus_ctrl_node (
  // Clock
  input wire logic clk,
  input wire logic rst_n,
  // Episode request
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [15:0] len,
  // Levels seen by the device
  output logic rx,
  output logic line_oc,
  output logic aux_oc
);
  // ****************************
  // Episode timer
  // ****************************
  logic [15:0] cnt_reg; // Cycles left in the episode
  logic [1:0] kind_reg; // 0 receive toggle, 1 line current, 2 aux current
  // Load on request, then count down; the line is inverted only while counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      kind_reg <= 2'h0;
    end else if (go) begin
      cnt_reg <= len;
      kind_reg <= kind;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
  // Opposite level for the whole pulse, back to idle afterwards
  assign rx = !(cnt_reg != 16'h0000 && kind_reg == 2'h0);
  assign line_oc = cnt_reg != 16'h0000 && kind_reg == 2'h1;
  assign aux_oc = cnt_reg != 16'h0000 && kind_reg == 2'h2;
endmodule

//--- tb/test_wakeup_and_current_limit_ctrl.sv
// Self-checking bench for the wake-up and current-limit control.
// Assumes short retry and blanking parameters; the far side is bus_ctrl_node.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_wakeup_and_current_limit_ctrl;
  import wake_limit_pkg::*;
  // ****************************
  // Stimulus and wiring
  // ****************************
  logic clk = 0, rst_n = 0, mode = 0, wdis = 0, clr = 0, tx = 1, len_en = 0;
  logic aux_en = 1, lretry = 1;
  logic [7:0] lreg = 8'h7f, areg = 8'hc0;
  strap_t lstrap = STRAP_GND, astrap = STRAP_GND;
  logic go = 0;
  logic [1:0] kind = 2'h0;
  logic [15:0] len = 16'h0000;
  logic rx, loc, aoc, oe, flag, hil, lall, aall, lsink, asink, lfoe, afoe;
  logic [2:0] llim, alim;
  int checks = 0, mismatches = 0;
  bus_ctrl_node far (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind), .len(len), .rx(rx),
    .line_oc(loc), .aux_oc(aoc));
  // Short counts keep the fault tests brief
  wakeup_and_current_limit_ctrl #(.RETRY_CYCLES(50), .BLANK_CYCLES(20)) uut (
    .SYS_CLK(clk), .RST_N(rst_n), .MODE_SERIAL(mode), .WAKE_SIGNAL_DISABLE(wdis),
    .LINE_LIMIT_REG(lreg), .AUX_OUT_LIMIT_REG(areg), .LINE_AUTO_RETRY(lretry),
    .AUX_AUTO_RETRY(1'b1), .LINE_LIMIT_STRAP(lstrap), .AUX_LIMIT_STRAP(astrap),
    .STRAP_LIMIT_CODE_LINE(3'h5), .STRAP_LIMIT_CODE_AUX(3'h2),
    .LINE_DRIVER_ENABLE(len_en), .LINE_TRANSMIT_IN(tx), .LINE_RECEIVE_OUT(rx),
    .LINE_OVER_CUR(loc), .AUX_DRIVER_ENABLE(aux_en), .AUX_OVER_CUR(aoc),
    .WAKE_NOTIFY_PIN_O(), .WAKE_NOTIFY_PIN_OE(oe), .WAKE_IRQ_FLAG(flag),
    .WAKE_IRQ_CLEAR(clr), .WAKE_HIGH_LEVEL(hil), .LINE_OUTPUT_CURRENT_LIMIT(llim),
    .AUX_OUTPUT_CURRENT_LIMIT(alim), .LINE_OUT_ALLOW(lall), .AUX_OUT_ALLOW(aall),
    .LINE_SINK_ON(lsink), .AUX_SINK_ON(asink), .LINE_FAULT_N_O(),
    .LINE_FAULT_N_OE(lfoe), .AUX_FAULT_N_O(), .AUX_FAULT_N_OE(afoe));
  // 25 MHz clock
  initial begin
    forever #20 clk = !clk;
  end
  // ****************************
  // Tasks
  // ****************************
  // One-cycle request to the far side
  task automatic fire(input logic [1:0] k, input logic [15:0] n);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    len <= n;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Episode, then count the low-driven wake cycles; the window outlasts the pulse
  task automatic run(input logic [1:0] k, input logic [15:0] n, input logic exp);
    int hi;
    hi = 0;
    fire(k, n);
    repeat (n + 3000) begin
      @(negedge clk);
      if (oe === 1'b1) hi++;
    end
    `CHK(hi, exp ? WAKE_PULSE_CYC : 0)
  endtask
  // Wait a number of settled samples
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************
  // Tests
  // ****************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Let the input synchronisers flush before the first episode
    idle(10);
    // Strap mode, driver off: receive toggles
    run(2'h0, 16'd2000, 1'b1);
    `CHK(flag, 1'b0)
    run(2'h0, 16'd1000, 1'b0);
    $display("test strap receive wake done");
    @(posedge clk) len_en <= 1'b1;
    run(2'h1, 16'd2000, 1'b1);
    `CHK(hil, 1'b1)
    @(posedge clk) tx <= 1'b0;
    run(2'h1, 16'd2000, 1'b1);
    `CHK(hil, 1'b0)
    run(2'h1, 16'd1000, 1'b0);
    run(2'h1, 16'd3000, 1'b0);
    run(2'h2, 16'd2000, 1'b0);
    `CHK(llim, 3'h5)
    `CHK(alim, 3'h2)
    $display("test current wake done");
    // Register mode: flag, clear, disable, limit fields
    @(posedge clk) mode <= 1'b1;
    run(2'h1, 16'd2000, 1'b1);
    `CHK(flag, 1'b1)
    `CHK(llim, 3'h3)
    `CHK(alim, 3'h6)
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    idle(2);
    `CHK(flag, 1'b0)
    @(posedge clk) wdis <= 1'b1;
    run(2'h1, 16'd2000, 1'b0);
    `CHK(flag, 1'b0)
    // Retry disabled: output stays on, fault pin stays quiet in register mode
    @(posedge clk) lretry <= 1'b0;
    fire(2'h1, 16'd200);
    idle(60);
    `CHK(lall, 1'b1)
    `CHK(lfoe, 1'b0)
    idle(200);
    @(posedge clk) lretry <= 1'b1;
    $display("test register mode done");
    // Strap faults: resistor blanks and retries, open reports at once
    @(posedge clk) begin
      mode <= 1'b0;
      lstrap <= STRAP_RES;
    end
    fire(2'h1, 16'd200);
    idle(40);
    `CHK(lfoe, 1'b1)
    `CHK(lall, 1'b0)
    idle(400);
    `CHK(lfoe, 1'b0)
    fire(2'h1, 16'd12);
    idle(10);
    `CHK(lfoe, 1'b0)
    @(posedge clk) lstrap <= STRAP_OPEN;
    idle(40);
    fire(2'h1, 16'd12);
    idle(10);
    `CHK(lfoe, 1'b1)
    `CHK(lall, 1'b1)
    // Grounded line strap: no fault, sink when the driver is off; resistor aux strap faults
    @(posedge clk) begin
      lstrap <= STRAP_GND;
      astrap <= STRAP_RES;
    end
    fire(2'h1, 16'd100);
    idle(60);
    `CHK(lfoe, 1'b0)
    `CHK(lall, 1'b1)
    `CHK(lsink, 1'b0)
    fire(2'h2, 16'd100);
    idle(60);
    `CHK(afoe, 1'b1)
    // Wake with the driver on, then the local controller returns to receive
    fire(2'h1, 16'd2000);
    idle(2010);
    `CHK(oe, 1'b1)
    @(posedge clk) len_en <= 1'b0;
    idle(10);
    `CHK(lsink, 1'b1)
    $display("test faults done");
    wrap_up();
  end
  // Hang guard, well beyond the roughly 50000 cycles the tests take
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
